// file: logic/par_cfg.svh
// Constants of the private address resolver: offsets, fields, timing.
// Assumes a 50 MHz system clock and APB byte addresses in paddr[11:0].
`ifndef PAR_CFG_SVH
`define PAR_CFG_SVH

`define PAR_OFS_START 12'h000
`define PAR_OFS_STOP 12'h008
`define PAR_OFS_END 12'h100
`define PAR_OFS_MATCH 12'h104
`define PAR_OFS_NOMATCH 12'h108
`define PAR_OFS_IRQ_SET 12'h304
`define PAR_OFS_IRQ_CLR 12'h308
`define PAR_OFS_INDEX 12'h400
`define PAR_OFS_ENABLE 12'h500
`define PAR_OFS_COUNT 12'h504
`define PAR_OFS_KEY_PTR 12'h508
`define PAR_OFS_ADDR_PTR 12'h510
`define PAR_OFS_SCR_PTR 12'h514
`define PAR_OFS_PENDING 12'h600
`define PAR_OFS_EV_CLR 12'h604

`define PAR_EV_END 0
`define PAR_EV_MATCH 1
`define PAR_EV_NOMATCH 2

`define PAR_ENABLE_OFF 2'h0
`define PAR_ENABLE_ON 2'h3
`define PAR_COUNT_RST 5'h01
`define PAR_KEYS_MAX 16
`define PAR_KEY_BYTES 32'h10

`define PAR_CLK_PERIOD_NS 20
`define PAR_PER_KEY_NS 6000
`define PAR_OVERHEAD_NS 1000
`define PAR_PER_KEY_CYC (`PAR_PER_KEY_NS / `PAR_CLK_PERIOD_NS)
`define PAR_OVERHEAD_CYC (`PAR_OVERHEAD_NS / `PAR_CLK_PERIOD_NS)

`endif

// file: logic/par_pkg.sv
// Types of the private address resolver.
// Assumes the constants header is included by the design file.
package par_pkg;

  typedef enum logic [2:0] {
    PAR_IDLE,
    PAR_ADDR,
    PAR_KEY,
    PAR_SCR,
    PAR_PAD,
    PAR_DONE
  } par_state_t;

  typedef struct packed {
    par_state_t st;
    logic [1:0] enable;
    logic [4:0] key_count;
    logic [31:0] key_ptr;
    logic [31:0] addr_ptr;
    logic [31:0] scr_ptr;
    logic [3:0] match_idx;
    logic [2:0] ev;
    logic [2:0] irq_en;
    logic [3:0] key_idx;
    logic [1:0] word;
    logic [127:0] key;
    logic [47:0] rx_addr;
    logic [12:0] tmr;
    logic stop_req;
    logic mem_req;
    logic mem_we;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic irq;
  } par_regs_t;

endpackage

// file: logic/par_resolver.sv
// Private address resolver: APB register file, RAM master and sequencer.
// Assumes a single-word RAM port on the same clock that acks each
// request with a one-cycle pulse, and word-aligned pointers.
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ns
`include "par_cfg.svh"

module par_resolver
  import par_pkg::*;
#(
  parameter int MAX_KEYS = `PAR_KEYS_MAX,
  parameter int PER_KEY_CYC = `PAR_PER_KEY_CYC,
  parameter int OVERHEAD_CYC = `PAR_OVERHEAD_CYC
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // RAM master
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Interrupt
  output logic irq_o
);

  par_regs_t r;
  par_regs_t n;

  // Stand-in for the cipher core: folds key and random part to 24 bits.
  // Same in and out widths as the real hash, so the compare is unchanged.
  function automatic logic [23:0] par_hash(
    input logic [127:0] key,
    input logic [23:0] prand
  );
    logic [143:0] wide;
    logic [23:0] h;
    wide = {16'h0000, key};
    h = prand;
    for (int i = 0; i < 6; i++) begin
      h = {h[22:0], h[23]} ^ wide[24*i +: 24];
    end
    return h;
  endfunction

  // Out-of-range counts are clamped so the walk always ends.
  function automatic logic [4:0] par_eff_count(input logic [4:0] k);
    if (k == 5'h00) begin
      return 5'h01;
    end else if (k > 5'(MAX_KEYS)) begin
      return 5'(MAX_KEYS);
    end else begin
      return k;
    end
  endfunction

  // Earliest cycle at which key idx may finish.
  function automatic logic [12:0] par_target(input logic [3:0] idx);
    int t;
    t = OVERHEAD_CYC + (int'(idx) + 1) * PER_KEY_CYC - 1;
    return 13'(t);
  endfunction

  always_comb begin
    logic access;
    logic wr;
    logic [31:0] rdata;
    logic hit;
    logic busy;
    logic [23:0] hash;
    logic [4:0] cnt;
    access = psel_i & penable_i;
    wr = access & r.pready & pwrite_i;
    rdata = 32'h0000_0000;
    hit = 1'b1;
    busy = (r.st != PAR_IDLE);
    hash = par_hash(r.key, r.rx_addr[47:24]);
    cnt = par_eff_count(r.key_count);
    n = r;
    n.pready = 1'b0;
    n.pslverr = 1'b0;

    // Register read decode
    if (paddr_i == `PAR_OFS_START) begin
      rdata = 32'h0000_0000;
    end else if (paddr_i == `PAR_OFS_STOP) begin
      rdata = 32'h0000_0000;
    end else if (paddr_i == `PAR_OFS_END) begin
      rdata = {31'h0, r.ev[`PAR_EV_END]};
    end else if (paddr_i == `PAR_OFS_MATCH) begin
      rdata = {31'h0, r.ev[`PAR_EV_MATCH]};
    end else if (paddr_i == `PAR_OFS_NOMATCH) begin
      rdata = {31'h0, r.ev[`PAR_EV_NOMATCH]};
    end else if (paddr_i == `PAR_OFS_IRQ_SET) begin
      rdata = {29'h0, r.irq_en};
    end else if (paddr_i == `PAR_OFS_IRQ_CLR) begin
      rdata = {29'h0, r.irq_en};
    end else if (paddr_i == `PAR_OFS_INDEX) begin
      rdata = {28'h0, r.match_idx};
    end else if (paddr_i == `PAR_OFS_ENABLE) begin
      rdata = {30'h0, r.enable};
    end else if (paddr_i == `PAR_OFS_COUNT) begin
      rdata = {27'h0, r.key_count};
    end else if (paddr_i == `PAR_OFS_KEY_PTR) begin
      rdata = r.key_ptr;
    end else if (paddr_i == `PAR_OFS_ADDR_PTR) begin
      rdata = r.addr_ptr;
    end else if (paddr_i == `PAR_OFS_SCR_PTR) begin
      rdata = r.scr_ptr;
    end else if (paddr_i == `PAR_OFS_PENDING) begin
      rdata = {29'h0, r.ev};
    end else if (paddr_i == `PAR_OFS_EV_CLR) begin
      rdata = 32'h0000_0000;
    end else begin
      hit = 1'b0;
    end

    // One wait state: data and error are registered on the same edge as pready
    if (access && !r.pready) begin
      n.pready = 1'b1;
      n.prdata = pwrite_i ? 32'h0000_0000 : rdata;
      n.pslverr = ~hit;
    end

    // Writes land on the edge that completes the access
    if (wr) begin
      if (paddr_i == `PAR_OFS_START) begin
        if (pwdata_i[0] && !busy && r.enable == `PAR_ENABLE_ON) begin
          n.st = PAR_ADDR;
          n.key_idx = 4'h0;
          n.word = 2'h0;
          n.tmr = 13'h0000;
          n.stop_req = 1'b0;
        end
      end else if (paddr_i == `PAR_OFS_STOP) begin
        if (pwdata_i[0] && busy) begin
          n.stop_req = 1'b1;
        end
      end else if (paddr_i == `PAR_OFS_END) begin
        if (!pwdata_i[0]) begin
          n.ev[`PAR_EV_END] = 1'b0;
        end
      end else if (paddr_i == `PAR_OFS_MATCH) begin
        if (!pwdata_i[0]) begin
          n.ev[`PAR_EV_MATCH] = 1'b0;
        end
      end else if (paddr_i == `PAR_OFS_NOMATCH) begin
        if (!pwdata_i[0]) begin
          n.ev[`PAR_EV_NOMATCH] = 1'b0;
        end
      end else if (paddr_i == `PAR_OFS_IRQ_SET) begin
        n.irq_en = r.irq_en | pwdata_i[2:0];
      end else if (paddr_i == `PAR_OFS_IRQ_CLR) begin
        n.irq_en = r.irq_en & ~pwdata_i[2:0];
      end else if (paddr_i == `PAR_OFS_ENABLE) begin
        n.enable = pwdata_i[1:0];
      end else if (paddr_i == `PAR_OFS_COUNT) begin
        n.key_count = pwdata_i[4:0];
      end else if (paddr_i == `PAR_OFS_KEY_PTR) begin
        n.key_ptr = pwdata_i;
      end else if (paddr_i == `PAR_OFS_ADDR_PTR) begin
        n.addr_ptr = pwdata_i;
      end else if (paddr_i == `PAR_OFS_SCR_PTR) begin
        n.scr_ptr = pwdata_i;
      end else if (paddr_i == `PAR_OFS_EV_CLR) begin
        n.ev = n.ev & ~pwdata_i[2:0];
      end
    end

    if (busy && r.tmr != 13'h1fff) begin
      n.tmr = r.tmr + 13'h0001;
    end

    // Stop is taken only between RAM accesses, never mid-transfer
    if (r.stop_req && !r.mem_req && busy && r.st != PAR_DONE) begin
      n.st = PAR_DONE;
    end else begin
      case (r.st)
        PAR_IDLE: begin
          n.mem_req = 1'b0;
        end
        PAR_ADDR: begin
          if (!r.mem_req) begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.addr_ptr + {28'h0, r.word, 2'b00};
          end else if (mem_ack_i) begin
            n.mem_req = 1'b0;
            if (r.word == 2'h0) begin
              n.rx_addr[31:0] = mem_rdata_i;
              n.word = 2'h1;
            end else begin
              n.rx_addr[47:32] = mem_rdata_i[15:0];
              n.word = 2'h0;
              n.st = PAR_KEY;
            end
          end
        end
        PAR_KEY: begin
          if (!r.mem_req) begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b0;
            n.mem_addr = r.key_ptr
              + (`PAR_KEY_BYTES * {28'h0, r.key_idx})
              + {28'h0, r.word, 2'b00};
          end else if (mem_ack_i) begin
            n.mem_req = 1'b0;
            n.key[32*r.word +: 32] = mem_rdata_i;
            n.word = r.word + 2'h1;
            if (r.word == 2'h3) begin
              n.st = PAR_SCR;
            end
          end
        end
        PAR_SCR: begin
          if (!r.mem_req) begin
            n.mem_req = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = r.scr_ptr;
            n.mem_wdata = {8'h00, hash};
          end else if (mem_ack_i) begin
            n.mem_req = 1'b0;
            n.mem_we = 1'b0;
            n.st = PAR_PAD;
          end
        end
        PAR_PAD: begin
          if (r.tmr >= par_target(r.key_idx)) begin
            if (hash == r.rx_addr[23:0]) begin
              n.ev[`PAR_EV_MATCH] = 1'b1;
              n.match_idx = r.key_idx;
              n.st = PAR_DONE;
            end else if ({1'b0, r.key_idx} + 5'h01 >= cnt) begin
              n.ev[`PAR_EV_NOMATCH] = 1'b1;
              n.st = PAR_DONE;
            end else begin
              n.key_idx = r.key_idx + 4'h1;
              n.st = PAR_KEY;
            end
          end
        end
        PAR_DONE: begin
          n.ev[`PAR_EV_END] = 1'b1;
          n.stop_req = 1'b0;
          n.st = PAR_IDLE;
        end
        default: begin
          n.st = PAR_IDLE;
        end
      endcase
    end

    n.irq = |(n.ev & n.irq_en);
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r.st <= PAR_IDLE;
      r.enable <= `PAR_ENABLE_OFF;
      r.key_count <= `PAR_COUNT_RST;
      r.key_ptr <= 32'h0000_0000;
      r.addr_ptr <= 32'h0000_0000;
      r.scr_ptr <= 32'h0000_0000;
      r.match_idx <= 4'h0;
      r.ev <= 3'h0;
      r.irq_en <= 3'h0;
      r.key_idx <= 4'h0;
      r.word <= 2'h0;
      r.key <= 128'h0;
      r.rx_addr <= 48'h0;
      r.tmr <= 13'h0000;
      r.stop_req <= 1'b0;
      r.mem_req <= 1'b0;
      r.mem_we <= 1'b0;
      r.mem_addr <= 32'h0000_0000;
      r.mem_wdata <= 32'h0000_0000;
      r.pready <= 1'b0;
      r.prdata <= 32'h0000_0000;
      r.pslverr <= 1'b0;
      r.irq <= 1'b0;
    end else begin
      r <= n;
    end
  end

  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign mem_req_o = r.mem_req;
  assign mem_we_o = r.mem_we;
  assign mem_addr_o = r.mem_addr;
  assign mem_wdata_o = r.mem_wdata;
  assign irq_o = r.irq;

endmodule // par_resolver

// file: testbench/par_ram_model.sv
// System RAM on the resolver's master port, with access bookkeeping.
// Assumes requests held until ack, on the design's clock.
`timescale 1ns/1ns

module par_ram_model #(
  parameter logic [31:0] KEY_PTR = 32'h100,
  parameter logic [31:0] ADDR_PTR = 32'h40,
  parameter logic [31:0] SCR_PTR = 32'h80
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // RAM slave
  input wire logic mem_req_i,
  input wire logic mem_we_i,
  input wire logic [31:0] mem_addr_i,
  input wire logic [31:0] mem_wdata_i,
  input wire logic [3:0] wait_i,
  output logic mem_ack_o,
  output logic [31:0] mem_rdata_o
);
  logic [31:0] mem [0:255];
  int cnt;
  int k;
  int addr_rd;
  int key_rd;
  int scr_wr;
  int bad;

  always @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mem_ack_o <= 1'b0;
      mem_rdata_o <= 32'h0;
      {cnt, k, addr_rd, key_rd, scr_wr, bad} <= '0;
    end else if (mem_ack_o) begin
      // Released data is inverted so a late sample cannot pass
      mem_ack_o <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o;
      cnt <= 0;
    end else if (mem_req_i && cnt < int'(wait_i)) begin
      cnt <= cnt + 1;
    end else if (mem_req_i) begin
      mem_ack_o <= 1'b1;
      mem_rdata_o <= mem[mem_addr_i[9:2]];
      if (mem_we_i) begin
        mem[mem_addr_i[9:2]] <= mem_wdata_i;
        if (mem_addr_i - SCR_PTR < 32'h10) scr_wr <= scr_wr + 1;
        else bad <= bad + 1;
      end else if (mem_addr_i - ADDR_PTR < 32'h8) begin
        addr_rd <= addr_rd + 1;
        k <= 0;
      end else if (mem_addr_i == KEY_PTR + 32'(4 * k)) begin
        key_rd <= key_rd + 1;
        k <= k + 1;
      end else begin
        bad <= bad + 1;
      end
    end
  end
endmodule // par_ram_model

// file: testbench/par_resolver_assertions.sv
// Port checker for the private address resolver, bound to the design.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns

module par_resolver_chk (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // APB
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pready_o,
  // RAM and interrupt
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic irq_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  apb_one_wait_a:
    assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer not after one wait state");
  ready_pulse_a:
    assert property (pready_o |=> !pready_o)
    else $error("pready held over one cycle");
  rst_quiet_a:
    assert property ($rose(nrst_i) |-> !irq_o && !mem_req_o)
    else $error("outputs active after reset");
  req_hold_a:
    assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
      $stable(mem_addr_o) && $stable(mem_we_o))
    else $error("ram request changed before ack");
  req_drop_a:
    assert property (mem_ack_i |=> !mem_req_o)
    else $error("ram request kept after ack");
  word_align_a:
    assert property (mem_req_o |-> mem_addr_o[1:0] == 2'h0)
    else $error("ram address not word aligned");
  scratch_data_a:
    assert property (mem_req_o && mem_we_o |-> mem_wdata_o[31:24] == 8'h00)
    else $error("scratch word top byte not zero");
  irq_clear_a:
    assert property (psel_i && penable_i && pready_o && pwrite_i &&
      paddr_i == 12'h308 && pwdata_i[2:0] == 3'h7 |-> ##[1:2] !irq_o)
    else $error("irq high with all enables cleared");
endmodule // par_resolver_chk

bind par_resolver par_resolver_chk u_chk (.clock_i(clock_i),
  .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .pready_o(pready_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_ack_i(mem_ack_i), .irq_o(irq_o));

// file: testbench/par_resolver_tb.sv
// Self-checking bench of the private address resolver.
// Assumes the checker and RAM model are compiled before it.
`timescale 1ns/1ns
`include "par_cfg.svh"

module par_resolver_tb;
  localparam int PK = 40;
  localparam int OVH = 8;
  localparam logic [31:0] KP = 32'h100;
  localparam logic [31:0] AP = 32'h40;
  localparam logic [23:0] PR = 24'h5a3c71;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] wait_cyc = 4'h0;
  logic [31:0] prdata, mem_addr, mem_wdata, mem_rdata, rdat;
  logic pready, pslverr, mem_req, mem_we, mem_ack, irq, rerr;
  int fail_count, checked, last_idx;

  par_resolver #(.PER_KEY_CYC(PK), .OVERHEAD_CYC(OVH)) DUT (
    .clock_i(clock), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .mem_req_o(mem_req), .mem_we_o(mem_we), .mem_addr_o(mem_addr),
    .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack), .mem_rdata_i(mem_rdata),
    .irq_o(irq));
  par_ram_model #(.KEY_PTR(KP), .ADDR_PTR(AP)) ram (.clock_i(clock),
    .nrst_i(nrst), .mem_req_i(mem_req), .mem_we_i(mem_we),
    .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .wait_i(wait_cyc),
    .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

  always #10 clock = ~clock;

  task finish_test;
    if (fail_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checked++;
    if (seen !== ex) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    // Values read here are those sampled at this rising edge
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      finish_test;
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, ex);
  endtask

  // Stand-in fold used by the resolver to compare hashes
  function automatic logic [23:0] fold(logic [127:0] key, logic [23:0] p);
    logic [143:0] kx;
    logic [23:0] h;
    kx = {16'h0, key};
    h = p;
    for (int i = 0; i < 6; i++) h = {h[22:0], h[23]} ^ kx[24 * i +: 24];
    return h;
  endfunction

  task reset_values;
    rdc("irq set", `PAR_OFS_IRQ_SET, 32'h0);
    rdc("index", `PAR_OFS_INDEX, 32'h0);
    rdc("enable", `PAR_OFS_ENABLE, 32'h0);
    rdc("count", `PAR_OFS_COUNT, 32'h1);
    wr(`PAR_OFS_START, 32'h1);
    repeat (30) @(posedge clock);
    chk("idle ram", 32'(ram.addr_rd), 32'h0);
  endtask

  task irq_masks;
    wr(`PAR_OFS_IRQ_SET, 32'h5);
    wr(`PAR_OFS_IRQ_SET, 32'h0);
    rdc("irq set", `PAR_OFS_IRQ_SET, 32'h5);
    wr(`PAR_OFS_IRQ_CLR, 32'h1);
    rdc("irq clr", `PAR_OFS_IRQ_CLR, 32'h4);
    wr(`PAR_OFS_IRQ_CLR, 32'h4);
    rdc("irq set", `PAR_OFS_IRQ_SET, 32'h0);
  endtask

  task bad_access;
    apb(1'b0, 12'h00c, 32'h0);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    wr(`PAR_OFS_INDEX, 32'hf);
    rdc("ro index", `PAR_OFS_INDEX, 32'h0);
  endtask

  task setup;
    ram.mem[AP[9:2]] = {PR[7:0], fold(128'h0, PR)};
    ram.mem[AP[9:2] + 1] = {16'hbeef, PR[23:8]};
    wr(`PAR_OFS_KEY_PTR, KP);
    wr(`PAR_OFS_ADDR_PTR, AP);
    wr(`PAR_OFS_SCR_PTR, 32'h80);
    wr(`PAR_OFS_ENABLE, 32'h3);
    rdc("key ptr", `PAR_OFS_KEY_PTR, KP);
  endtask

  // Key m is the only zero key, so it alone resolves the address
  task run(input int n, input int m, input logic [3:0] wt);
    int c, t, k0, s0, a0;
    t = (m < n) ? m + 1 : n;
    for (int i = 0; i < 64; i++)
      ram.mem[KP[9:2] + i] = (i % 4 == 0 && i / 4 != m) ? 32'(i + 4) : 32'h0;
    {k0, s0, a0} = {ram.key_rd, ram.scr_wr, ram.addr_rd};
    @(posedge clock);
    wait_cyc <= wt;
    wr(`PAR_OFS_COUNT, 32'(n));
    wr(`PAR_OFS_EV_CLR, 32'h7);
    wr(`PAR_OFS_IRQ_SET, 32'h1);
    wr(`PAR_OFS_START, 32'h1);
    c = 0;
    do begin
      @(negedge clock);
      c++;
    end while (irq !== 1'b1 && c < 2000);
    if (c >= 2000) begin
      fail_count++;
      finish_test;
    end
    if (m < n) last_idx = m;
    chk("time", 32'(c >= PK * t && c <= OVH + PK * t + 6), 32'h1);
    rdc("end ev", `PAR_OFS_END, 32'h1);
    rdc("match ev", `PAR_OFS_MATCH, 32'(m < n));
    rdc("no match ev", `PAR_OFS_NOMATCH, 32'(m >= n));
    rdc("index", `PAR_OFS_INDEX, 32'(last_idx));
    chk("addr reads", 32'(ram.addr_rd - a0), 32'h2);
    chk("key reads", 32'(ram.key_rd - k0), 32'(4 * t));
    chk("scratch", 32'(ram.scr_wr - s0), 32'(t));
    chk("stray", 32'(ram.bad), 32'h0);
    wr(`PAR_OFS_IRQ_CLR, 32'h7);
    @(negedge clock);
    chk("irq off", {31'h0, irq}, 32'h0);
  endtask

  // Stop mid-walk: only the end event rises, and the enables gate the irq
  task stop_run;
    wr(`PAR_OFS_EV_CLR, 32'h7);
    wr(`PAR_OFS_IRQ_SET, 32'h6);
    wr(`PAR_OFS_START, 32'h1);
    repeat (100) @(posedge clock);
    wr(`PAR_OFS_STOP, 32'h1);
    repeat (20) @(posedge clock);
    rdc("pending", `PAR_OFS_PENDING, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`PAR_OFS_IRQ_SET, 32'h1);
    @(negedge clock);
    chk("irq end", {31'h0, irq}, 32'h1);
    wr(`PAR_OFS_IRQ_CLR, 32'h7);
  endtask

  initial begin
    last_idx = 0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    reset_values;
    irq_masks;
    bad_access;
    setup;
    run(4, 2, 4'h2);
    run(8, 31, 4'h0);
    run(16, 15, 4'h0);
    run(16, 31, 4'h1);
    stop_run;
    finish_test;
  end
endmodule // par_resolver_tb
